/* File: hdl/svr_pkg.sv */
package svr_pkg;
	// Register offsets and fields
	localparam logic [7:0] REG_LINK_PRESENCE  = 8'h1c;
	localparam logic [7:0] REG_SPREAD_CFG     = 8'h2c;
	localparam logic [7:0] REG_ERR_TALLY      = 8'h41;
	localparam logic [7:0] REG_LINK_CTRL      = 8'h02;
	localparam int         LINK_PRESENT_BIT   = 0;
	localparam int         CTRL_LEGACY_BIT    = 0;
	localparam int         CTRL_FILTER_BIT    = 1;
	localparam int         CTRL_LFRANGE_BIT   = 2;
	localparam int         CTRL_SPREAD_EN_BIT = 3;
	localparam logic [7:0] SPREAD_CFG_RESET   = 8'h00;
	localparam logic [7:0] LINK_CTRL_RESET    = 8'h02;
	// Payload widths
	localparam int         WORD_W             = 35;
	localparam int         LEGACY_W           = 28;
	localparam int         COLOR_W            = 8;
	// Pixel clock limits in kHz, then line rate, clock and return channel settings
	localparam int         PCLK_MIN_KHZ       = 5000;
	localparam int         PCLK_MAX_KHZ       = 85000;
	localparam int         LEGACY_MIN_KHZ     = 15000;
	localparam int         LEGACY_MAX_KHZ     = 65000;
	localparam int         LINE_MIN_MBPS      = 525;
	localparam int         LINE_MAX_MBPS_X1K  = 2975;
	localparam int         RETURN_MBPS        = 10;
	localparam int         CLK_MHZ            = 10;
	localparam int         RETURN_DIV         = CLK_MHZ / RETURN_MBPS;
	localparam int         RETURN_FRAME_W     = 16;
	localparam int         GPIO_W             = 4;
	// Control signal filter
	localparam int         SYNC_WINDOW        = 130;
	localparam int         SYNC_MIN_PULSE     = 3;
	localparam int         SYNC_MAX_TOGGLES   = 2;
	// Sleep detection: words missing before sleep
	localparam logic [7:0] STOP_WORDS         = 8'h20;
	// Error tally
	localparam logic [4:0] ERR_MAX            = 5'h1f;
	// Spread modulation dividers
	localparam logic [11:0] DIV_HI_A          = 12'd2168;
	localparam logic [11:0] DIV_HI_B          = 12'd1300;
	localparam logic [11:0] DIV_LO_A          = 12'd628;
	localparam logic [11:0] DIV_LO_B          = 12'd388;
	// Display feed buffer depth
	localparam int         FIFO_DEPTH         = 8;
	typedef enum logic [1:0] {
		ST_DOWN  = 2'b00,
		ST_SLEEP = 2'b01,
		ST_LOCK  = 2'b10
	} svr_state_t;
endpackage : svr_pkg

/* File: hdl/svr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module svr_fifo #(
	parameter int W = 35,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_ff != D[AW:0]);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : svr_fifo
`default_nettype wire

/* File: hdl/svr_receiver.sv */
// How it works
// RQ1: Take one 35-bit payload word per pixel clock from the pair.
// RQ2: Normal mode runs pixel clocks from 5 to 85 MHz.
// RQ3: Normal mode line rate spans 525 Mbps to 2.975 Gbps.
// RQ4: Send return channel at 10 Mbps: control bus, CRC, four GPIO bits.
// RQ5: Lock from embedded clock bits alone, any data pattern.
// RQ6: Legacy mode takes 28-bit words; pixel clock 15 to 65 MHz.
// RQ7: Filter on: active video and line sync pulses under 3 clocks rejected.
// RQ8: Filter off: sender limits those to two transitions per 130 clocks.
// RQ9: Sender keeps frame sync at one change per 130 clocks, 130 wide.
// RQ10: Spread enabled modulates clock and data outputs, up to 2.5 percent.
// RQ11: Low range low: dividers 2168 or 1300 by spread code.
// RQ12: Low range high: dividers 628 or 388 by spread code.
// RQ13: Sender should not enable spread on an already spread clock.
// RQ14: Red, green and blue output groups switch at different times.
// RQ15: Power-down input low disables link; high enables.
// RQ16: Sleep when clock bits vanish; relock when stream returns.
// RQ17: Registers keep their values through stream sleep.
// RQ18: Any of seven cable faults reads link present as 0.
// RQ19: Link errors counted in a 5-bit readable field.
// RQ20: Error count saturates at 31.
`timescale 1ns/1ps
`default_nettype none
module svr_receiver
	import svr_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              power_down_input_n,
	// Forward channel, one word per pixel clock
	input  wire logic              fwd_valid,
	input  wire logic [WORD_W-1:0] fwd_word,
	input  wire logic              fwd_clock_bits,
	input  wire logic              fwd_word_error,
	input  wire logic [6:0]        cable_fault,
	// Mode pin
	input  wire logic              legacy_sel,
	// Return channel
	input  wire logic [GPIO_W-1:0] return_gpio,
	input  wire logic [7:0]        return_ctrl,
	output logic                   return_channel,
	// Display outputs
	input  wire logic              disp_ready,
	output logic [COLOR_W-1:0]     red_out,
	output logic [COLOR_W-1:0]     green_out,
	output logic [COLOR_W-1:0]     blue_out,
	output logic                   active_video_flag,
	output logic                   line_sync,
	output logic                   frame_sync,
	output logic [3:0]             audio_out,
	output logic                   pixel_strobe,
	output logic                   lock_out,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic [7:0]             reg_rdata
);
	svr_state_t   st_ff;
	svr_state_t   nxt_st;
	logic [7:0]   ctrl_ff;
	logic [7:0]   spread_cfg_ff;
	logic [4:0]   err_ff;
	logic [7:0]   idle_ff;
	logic         link_ok;
	logic         fifo_in_ready;
	logic         drain_ok;
	logic         fifo_valid;
	logic [WORD_W-1:0] fifo_data;
	logic [WORD_W-1:0] word_in;
	logic         take;

	function automatic logic [11:0] mod_div(input logic lf, input logic [2:0] code);
		if (lf) begin
			mod_div = code[2] ? DIV_LO_B : DIV_LO_A; // [RQ12]
		end else begin
			mod_div = code[2] ? DIV_HI_B : DIV_HI_A; // [RQ11]
		end
	endfunction : mod_div

	// Power down and stream sleep
	assign link_ok = (st_ff == ST_LOCK);
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_DOWN: begin
				if (power_down_input_n) begin
					nxt_st = ST_SLEEP; // [RQ15]
				end
			end
			ST_SLEEP: begin
				if (fwd_clock_bits) begin
					nxt_st = ST_LOCK; // [RQ5] [RQ16]
				end
			end
			ST_LOCK: begin
				if (idle_ff == STOP_WORDS) begin
					nxt_st = ST_SLEEP; // [RQ16]
				end
			end
			default: nxt_st = ST_DOWN;
		endcase
		if (!power_down_input_n) begin
			nxt_st = ST_DOWN; // [RQ15]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_DOWN;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_ff <= '0;
		end else if (!link_ok || fwd_clock_bits) begin
			idle_ff <= '0;
		end else if (idle_ff != STOP_WORDS) begin
			idle_ff <= idle_ff + 8'h01;
		end
	end

	// Legacy words carry only the low 28 bits
	assign word_in = ctrl_ff[CTRL_LEGACY_BIT] | legacy_sel
		? {{(WORD_W - LEGACY_W){1'b0}}, fwd_word[LEGACY_W-1:0]} // [RQ6]
		: fwd_word; // [RQ1]
	assign take = link_ok & fwd_valid & fwd_clock_bits;

	// Stall the display feed; words seen while full count as errors
	svr_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (take),
		.in_ready  (fifo_in_ready),
		.in_data   (word_in),
		.out_valid (fifo_valid),
		.out_ready (drain_ok),
		.out_data  (fifo_data)
	);

	// Registers; only reset clears them, never sleep
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff       <= LINK_CTRL_RESET;
			spread_cfg_ff <= SPREAD_CFG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_LINK_CTRL) begin
				ctrl_ff <= reg_wdata; // [RQ17]
			end
			if (reg_addr == REG_SPREAD_CFG) begin
				spread_cfg_ff <= reg_wdata; // [RQ17]
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_ff <= '0;
		end else if ((fwd_word_error || (take && !fifo_in_ready)) && err_ff != ERR_MAX) begin
			err_ff <= err_ff + 5'h01; // [RQ19] [RQ20]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				REG_LINK_PRESENCE: reg_rdata <= {7'h00, link_ok & (cable_fault == 7'h00)}; // [RQ18]
				REG_SPREAD_CFG:    reg_rdata <= spread_cfg_ff;
				REG_ERR_TALLY:     reg_rdata <= {3'h0, err_ff}; // [RQ19]
				REG_LINK_CTRL:     reg_rdata <= ctrl_ff;
				default:           reg_rdata <= '0;
			endcase
		end
	end

	// Sync glitch filter: hold a change until stable for the minimum pulse
	logic [1:0] sync_raw;
	logic [1:0] sync_ff;
	logic [1:0] cand_ff;
	logic [1:0] run_ff [2];
	logic       pop;
	assign pop      = fifo_valid & drain_ok;
	assign sync_raw = {fifo_data[25], fifo_data[24]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_ff <= '0;
			cand_ff <= '0;
			run_ff  <= '{2'h0, 2'h0};
		end else if (pop) begin
			for (int i = 0; i < 2; i++) begin
				if (!ctrl_ff[CTRL_FILTER_BIT]) begin
					sync_ff[i] <= sync_raw[i]; // [RQ8]
				end else if (sync_raw[i] != cand_ff[i]) begin
					cand_ff[i]   <= sync_raw[i];
					run_ff[i]    <= 2'h1;
				end else if (run_ff[i] != 2'(SYNC_MIN_PULSE)) begin
					run_ff[i] <= run_ff[i] + 2'h1;
					if (run_ff[i] == 2'(SYNC_MIN_PULSE - 1)) begin
						sync_ff[i] <= cand_ff[i]; // [RQ7]
					end
				end
			end
		end
	end

	// Spread modulation: triangle offset on the output strobe pacing
	logic [11:0] mod_cnt_ff;
	logic        mod_up_ff;
	logic [2:0]  dev_ff;
	logic [2:0]  gap_ff;
	logic        spread_on;
	assign spread_on = ctrl_ff[CTRL_SPREAD_EN_BIT];
	// Hold the display feed during a gap, so no word leaves without its strobe
	assign drain_ok  = disp_ready & (gap_ff == 3'h0); // [RQ10]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mod_cnt_ff <= '0;
			mod_up_ff  <= 1'b1;
			dev_ff     <= '0;
		end else if (!spread_on) begin
			mod_cnt_ff <= '0;
			dev_ff     <= '0;
		end else if (mod_cnt_ff >= (mod_div(ctrl_ff[CTRL_LFRANGE_BIT], spread_cfg_ff[2:0]) >> 4)) begin
			mod_cnt_ff <= '0;
			if (mod_up_ff && dev_ff == {1'b0, spread_cfg_ff[1:0]}) begin
				mod_up_ff <= 1'b0;
			end else if (!mod_up_ff && dev_ff == 3'h0) begin
				mod_up_ff <= 1'b1;
			end else begin
				dev_ff <= mod_up_ff ? dev_ff + 3'h1 : dev_ff - 3'h1; // [RQ10]
			end
		end else begin
			mod_cnt_ff <= mod_cnt_ff + 12'h001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_ff <= '0;
		end else if (gap_ff != 3'h0) begin
			gap_ff <= gap_ff - 3'h1;
		end else if (pop) begin
			gap_ff <= dev_ff; // [RQ10]
		end
	end

	// Staggered outputs: green one cycle after red, blue after green
	logic [COLOR_W-1:0] g_dly_ff;
	logic [COLOR_W-1:0] b_dly_ff [2];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			red_out           <= '0;
			green_out         <= '0;
			blue_out          <= '0;
			g_dly_ff          <= '0;
			b_dly_ff          <= '{8'h00, 8'h00};
			active_video_flag <= 1'b0;
			line_sync         <= 1'b0;
			frame_sync        <= 1'b0;
			audio_out         <= '0;
			pixel_strobe      <= 1'b0;
		end else begin
			pixel_strobe <= pop;
			if (pop) begin
				red_out    <= fifo_data[7:0];
				g_dly_ff   <= fifo_data[15:8];
				b_dly_ff[0] <= fifo_data[23:16];
				frame_sync <= fifo_data[26]; // [RQ9]
				audio_out  <= fifo_data[30:27];
			end
			green_out         <= g_dly_ff; // [RQ14]
			b_dly_ff[1]       <= b_dly_ff[0];
			blue_out          <= b_dly_ff[1]; // [RQ14]
			active_video_flag <= sync_ff[0];
			line_sync         <= sync_ff[1];
		end
	end

	// Return channel: 16-bit frame of ctrl, CRC nibble and GPIO per 10 Mbps bit
	logic [RETURN_FRAME_W-1:0] ret_sh_ff;
	logic [3:0]                ret_cnt_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ret_sh_ff      <= '0;
			ret_cnt_ff     <= '0;
			return_channel <= 1'b0;
			lock_out       <= 1'b0;
		end else begin
			lock_out <= link_ok; // [RQ2] [RQ3]
			if (!link_ok) begin
				ret_cnt_ff     <= '0;
				return_channel <= 1'b0;
			end else begin
				if (ret_cnt_ff == 4'h0) begin
					ret_sh_ff <= {return_ctrl, return_ctrl[3:0] ^ return_ctrl[7:4] ^ return_gpio, return_gpio}; // [RQ4]
				end else begin
					ret_sh_ff <= {ret_sh_ff[RETURN_FRAME_W-2:0], 1'b0};
				end
				return_channel <= (ret_cnt_ff == 4'h0) ? return_ctrl[7] : ret_sh_ff[RETURN_FRAME_W-2]; // [RQ4]
				ret_cnt_ff     <= ret_cnt_ff + 4'h1;
			end
		end
	end
endmodule : svr_receiver
`default_nettype wire

/* File: tb/svr_receiver_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module svr_receiver_monitor
	import svr_pkg::*;
(
	// Watched ports
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       power_down_input_n,
	input wire logic       fwd_clock_bits,
	input wire logic [6:0] cable_fault,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       lock_out,
	input wire logic       active_video_flag,
	input wire logic       pixel_strobe
);
	logic [5:0] gap_ff;
	logic       filt_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) gap_ff <= 6'h00;
		else if (fwd_clock_bits) gap_ff <= 6'h00;
		else if (gap_ff != 6'h3f) gap_ff <= gap_ff + 6'h01;
	end
	// Shadow of the filter enable, since it is not visible at a port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) filt_ff <= LINK_CTRL_RESET[CTRL_FILTER_BIT];
		else if (reg_wr && reg_addr == REG_LINK_CTRL) filt_ff <= reg_wdata[CTRL_FILTER_BIT];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_POWER_DOWN: assert property (!power_down_input_n [*2] |=> !lock_out)
		else $error("lock held in power down");
	AST_SLEEP: assert property (gap_ff > 6'h23 |-> !lock_out)
		else $error("lock held without clock bits");
	AST_LOCK_CAUSE: assert property ($rose(lock_out) |-> $past(power_down_input_n) &&
		($past(fwd_clock_bits) || $past(fwd_clock_bits, 2))) else $error("lock without clock bits");
	AST_FAULT: assert property ((|cable_fault) [*3] ##0 reg_addr == REG_LINK_PRESENCE |=>
		!reg_rdata[LINK_PRESENT_BIT]) else $error("link present under fault");
	AST_TALLY_TOP: assert property (reg_addr == REG_ERR_TALLY |=> reg_rdata[7:5] == 3'h0)
		else $error("tally upper bits set");
	AST_TALLY_SAT: assert property ((reg_addr == REG_ERR_TALLY) [*2] ##0 reg_rdata[4:0] == ERR_MAX |=>
		reg_rdata[4:0] == ERR_MAX) else $error("tally left its ceiling");
	AST_SPREAD_KEEP: assert property (reg_wr && reg_addr == REG_SPREAD_CFG ##1 !reg_wr &&
		reg_addr == REG_SPREAD_CFG |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2)) else $error("spread code lost");
	AST_FILTER: assert property (filt_ff && $changed(active_video_flag) |=>
		$stable(active_video_flag) [*2]) else $error("short video flag pulse");
	cover property ($rose(lock_out));
	cover property (pixel_strobe ##1 pixel_strobe);
	cover property (reg_addr == REG_ERR_TALLY && reg_rdata[4:0] == ERR_MAX);
endmodule : svr_receiver_monitor
`default_nettype wire

/* File: tb/svr_serializer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module svr_serializer_model
	import svr_pkg::*;
(
	// Bench commands
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          go,
	input wire logic          slow,
	input wire logic          clk_on,
	input wire logic          av_lvl,
	input wire logic          glitch,
	// Decoded serial pair
	output logic              fwd_valid,
	output logic [WORD_W-1:0] fwd_word,
	output logic              fwd_clock_bits
);
	integer      seed = 32'hcae15777;
	logic [7:0]  n_ff;
	logic        fs_ff;
	logic [31:0] r_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			n_ff <= 8'h00;
			fs_ff <= 1'b0;
		end else if (fwd_valid) begin
			n_ff <= (n_ff == 8'h81) ? 8'h00 : n_ff + 8'h01;
			if (n_ff == 8'h81) fs_ff <= ~fs_ff;
		end
	end
	// New data every cycle, so an idle word never matches by luck
	always @(posedge clk) r_ff <= $random(seed);
	assign fwd_valid = go & (~slow | r_ff[31]);
	// Source clock is unspread, so spreading in the receiver is allowed
	assign fwd_clock_bits = clk_on;
	// Bench keeps level changes sparse; glitch is a deliberate short pulse
	assign fwd_word = {4'h0, r_ff[30:27], fs_ff, av_lvl ^ glitch, av_lvl ^ glitch, r_ff[23:0]};
endmodule : svr_serializer_model
`default_nettype wire

/* File: tb/tb_svr_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_svr_receiver
	import svr_pkg::*;
;
	localparam logic [7:0] RC = 8'ha5;
	localparam logic [3:0] RG = 4'h3;
	logic clk = 1'b0, rst = 1'b1, pdn = 1'b1, go = 1'b0, slow = 1'b0, clk_on = 1'b0, av_lvl = 1'b0;
	logic glitch = 1'b0, fwd_word_error = 1'b0, disp_ready = 1'b1, reg_wr = 1'b0, chk = 1'b0, leg = 1'b0, hit;
	logic fwd_valid, fwd_clock_bits, return_channel, active_video_flag, line_sync, frame_sync, pixel_strobe, lock_out;
	logic [7:0] red_out, green_out, blue_out, reg_rdata, reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [6:0] cable_fault = 7'h00;
	logic [3:0] audio_out;
	logic [34:0] fwd_word, ww0, ww1, q[$];
	logic [1:0] sv = 2'b00;
	logic [31:0] bits;
	logic [15:0] rq[$], rr;
	int fails = 0, n_compared = 0, i;
	always #50 clk = ~clk;
	svr_serializer_model u_svr_serializer_model (.clk(clk), .rst(rst), .go(go), .slow(slow), .clk_on(clk_on),
		.av_lvl(av_lvl), .glitch(glitch), .fwd_valid(fwd_valid), .fwd_word(fwd_word), .fwd_clock_bits(fwd_clock_bits));
	svr_receiver u_svr_receiver (.clk(clk), .rst(rst), .power_down_input_n(pdn), .fwd_valid(fwd_valid),
		.fwd_word(fwd_word), .fwd_clock_bits(fwd_clock_bits), .fwd_word_error(fwd_word_error),
		.cable_fault(cable_fault), .legacy_sel(leg), .return_gpio(RG), .return_ctrl(RC),
		.return_channel(return_channel), .disp_ready(disp_ready), .red_out(red_out), .green_out(green_out),
		.blue_out(blue_out), .active_video_flag(active_video_flag), .line_sync(line_sync), .frame_sync(frame_sync),
		.audio_out(audio_out), .pixel_strobe(pixel_strobe), .lock_out(lock_out), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// One idle edge, so a following write never drives the strobe twice in a step
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		reg_addr <= a;
		@(posedge clk);
		rq.push_back({m, e});
		chk <= 1'b1;
		@(posedge clk);
		chk <= 1'b0;
	endtask : rd
	task automatic wt(input logic v);
		for (int k = 0; k < 60 && lock_out !== v; k++) @(posedge clk);
		cmp({7'h0, lock_out}, {7'h0, v});
	endtask : wt
	// Stream with a two-word dip on the sync bits; dip says whether it must show
	task automatic burst(input logic [7:0] c, input logic lg, input logic dip);
		int k;
		wr(REG_LINK_CTRL, c);
		leg <= lg;
		go <= 1'b1;
		hit = 1'b0;
		for (k = 0; k < 120; k++) begin
			@(posedge clk);
			slow <= !(k >= 20 && k < 24);
			glitch <= (k == 21 || k == 22);
			if (k > 12) hit |= (active_video_flag !== 1'b1) | (line_sync !== 1'b1);
		end
		go <= 1'b0;
		for (k = 0; k < 60 && q.size() > 0; k++) @(posedge clk);
		cmp(8'(q.size()), 8'h00);
		cmp({7'h0, hit}, {7'h0, dip});
	endtask : burst
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Note each word the receiver takes; overflow drops are not expected out
	always @(posedge clk) begin
		bits <= {bits[30:0], return_channel};
		if (lock_out && fwd_valid && fwd_clock_bits && q.size() < FIFO_DEPTH)
			q.push_back(leg ? {7'h00, fwd_word[LEGACY_W-1:0]} : fwd_word);
	end
	always @(posedge clk) begin
		#1;
		if (sv[1]) cmp(blue_out, ww1[23:16]);
		if (sv[0]) cmp(green_out, ww0[15:8]);
		sv[1] = sv[0];
		ww1 = ww0;
		sv[0] = 1'b0;
		if (pixel_strobe === 1'b1) begin
			ww0 = (q.size() > 0) ? q.pop_front() : 'x;
			sv[0] = 1'b1;
			cmp(red_out, ww0[7:0]);
			cmp({4'h0, audio_out}, {4'h0, ww0[30:27]});
			cmp({7'h0, frame_sync}, {7'h0, ww0[26]});
		end
		if (chk) begin
			rr = rq.pop_front();
			cmp(reg_rdata & rr[15:8], rr[7:0]);
		end
	end
	initial begin
		#1000000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wr(REG_LINK_PRESENCE, 8'hff);
		rd(REG_LINK_PRESENCE, 8'h00, 8'h01);
		wr(8'h33, 8'hff);
		rd(8'h33, 8'h00, 8'hff);
		rd(REG_LINK_CTRL, LINK_CTRL_RESET, 8'hff);
		rd(REG_SPREAD_CFG, SPREAD_CFG_RESET, 8'hff);
		rd(REG_ERR_TALLY, 8'h00, 8'hff);
		clk_on <= 1'b1;
		wt(1'b1);
		$display("defaults and lock done");
		slow <= 1'b1;
		go <= 1'b1;
		av_lvl <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			glitch <= (i == 100);
		end
		cmp({7'h0, active_video_flag}, 8'h01);
		cmp({7'h0, line_sync}, 8'h01);
		hit = 1'b0;
		for (i = 0; i < 16; i++) hit |= (bits[i +: 16] === {RC, RC[3:0] ^ RC[7:4] ^ RG, RG});
		cmp({7'h0, hit}, 8'h01);
		go <= 1'b0;
		slow <= 1'b0;
		for (i = 0; i < 30 && q.size() > 0; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		disp_ready <= 1'b0;
		go <= 1'b1;
		repeat (10) @(posedge clk);
		go <= 1'b0;
		rd(REG_ERR_TALLY, 8'h02, 8'hff);
		cmp(8'(q.size()), 8'(FIFO_DEPTH));
		disp_ready <= 1'b1;
		for (i = 0; i < 30 && q.size() > 0; i++) @(posedge clk);
		cmp(8'(q.size()), 8'h00);
		$display("stream and buffer done");
		burst(8'h00, 1'b0, 1'b1);
		burst(LINK_CTRL_RESET, 1'b1, 1'b0);
		wr(REG_SPREAD_CFG, 8'h05);
		burst(8'h0e, 1'b0, 1'b0);
		wr(REG_LINK_CTRL, LINK_CTRL_RESET);
		$display("filter, legacy and spread done");
		for (i = 0; i < 7; i++) begin
			cable_fault <= 7'h01 << i;
			repeat (3) @(posedge clk);
			rd(REG_LINK_PRESENCE, 8'h00, 8'h01);
		end
		cable_fault <= 7'h00;
		repeat (3) @(posedge clk);
		rd(REG_LINK_PRESENCE, 8'h01, 8'h01);
		for (i = 0; i < 8; i++) begin
			wr(REG_SPREAD_CFG, 8'(i));
			rd(REG_SPREAD_CFG, 8'(i), 8'h07);
		end
		wr(REG_LINK_CTRL, 8'h06);
		rd(REG_LINK_CTRL, 8'h06, 8'h0f);
		wr(REG_LINK_CTRL, LINK_CTRL_RESET);
		wr(REG_SPREAD_CFG, 8'h05);
		clk_on <= 1'b0;
		wt(1'b0);
		rd(REG_SPREAD_CFG, 8'h05, 8'h07);
		clk_on <= 1'b1;
		wt(1'b1);
		$display("faults, spread and sleep done");
		fwd_word_error <= 1'b1;
		repeat (40) @(posedge clk);
		fwd_word_error <= 1'b0;
		rd(REG_ERR_TALLY, {3'h0, ERR_MAX}, 8'hff);
		rd(REG_ERR_TALLY, {3'h0, ERR_MAX}, 8'hff);
		pdn <= 1'b0;
		repeat (3) @(posedge clk);
		cmp({7'h0, lock_out}, 8'h00);
		pdn <= 1'b1;
		wt(1'b1);
		$display("tally and power down done");
		end_of_test();
	end
endmodule : tb_svr_receiver
bind svr_receiver svr_receiver_monitor u_svr_receiver_monitor (.clk(clk), .rst(rst),
	.power_down_input_n(power_down_input_n), .fwd_clock_bits(fwd_clock_bits), .cable_fault(cable_fault),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lock_out(lock_out),
	.active_video_flag(active_video_flag), .pixel_strobe(pixel_strobe));
`default_nettype wire
